// ==== hdl/slp_params.svh ====
`ifndef SLP_PARAMS_SVH
`define SLP_PARAMS_SVH

// Register word indexes; byte address is index times four
`define SLP_IDX_CTRL    6'h00
`define SLP_IDX_STATUS  6'h01
`define SLP_IDX_INSTR   6'h02
`define SLP_IDX_ARCH0   6'h03
`define SLP_ARCH_NUM    10

// Architectural register slots
`define SLP_R_GP1       4'h0
`define SLP_R_GP2       4'h1
`define SLP_R_GP3       4'h2
`define SLP_R_ACCF      4'h3
`define SLP_R_IDX1      4'h4
`define SLP_R_IDX2      4'h5
`define SLP_R_SP        4'h6
`define SLP_R_PC        4'h7
`define SLP_R_MSW       4'h8
`define SLP_R_LIMIT     4'h9

// Control and status fields
`define SLP_CTRL_START  0
`define SLP_CTRL_SYS    1
`define SLP_ST_BUSY     0
`define SLP_ST_DONE     1
`define SLP_ST_PRIV     2
`define SLP_ST_SSOW     3
`define SLP_ST_ILLEGAL  4
`define SLP_ST_W        5

// Condition flag positions in the flag byte
`define SLP_FLG_S       7
`define SLP_FLG_Z       6
`define SLP_FLG_PV      2
`define SLP_FLG_C       0

// Opcode bytes
`define SLP_OP_PFX_X    8'hDD
`define SLP_OP_PFX_Y    8'hFD
`define SLP_OP_PFX_BIT  8'hCB
`define SLP_OP_PFX_ED   8'hED
`define SLP_OP_PUSH_X   8'hE5
`define SLP_OP_PUSH_IM  8'hF5
`define SLP_OP_PUSH_IR  8'hC5
`define SLP_OP_PUSH_DA  8'hD5
`define SLP_OP_PUSH_RA  8'hF5
`define SLP_OP_RTN       8'hC9
`define SLP_OP_IRTN      8'h4D
`define SLP_OP_IRTN_LONG 8'h55

// Stack steps and reset values
`define SLP_STEP_WORD   16'h0002
`define SLP_STEP_LONG   16'h0004
`define SLP_RST_REG     16'h0000
`define SLP_RST_STATUS  5'h00

`endif

// ==== hdl/slp_pkg.sv ====
package slp_pkg;

  typedef enum logic [2:0] {
    SLP_S_IDLE, SLP_S_EXEC, SLP_S_RD, SLP_S_WR, SLP_S_SEQ, SLP_S_FIN
  } slp_state_t;

  typedef enum logic [2:0] {
    SLP_K_NONE, SLP_K_PUSH_MEM, SLP_K_BCLR_MEM, SLP_K_RTN, SLP_K_IRTN, SLP_K_IRTN_LONG
  } slp_kind_t;

  // Byte request towards the stack memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic        eoi;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } slp_mem_req_t;

  // Latched AHB address phase
  typedef struct packed {
    logic       wr;
    logic [5:0] idx;
  } slp_aphase_t;

endpackage

// ==== hdl/slp_exec_unit.sv ====
`timescale 1ns/100ps
`include "slp_params.svh"

module slp_exec_unit (
  // Condition test
  input  wire logic [7:0] flags,
  input  wire logic [2:0] cond_field,
  output logic            cond_met,
  // Bit clear
  input  wire logic [7:0] byte_in,
  input  wire logic [2:0] bit_num,
  output logic [7:0]      byte_out
);

  logic sel_flag;

  always_comb begin
    case (cond_field[2:1])
      2'b00:   sel_flag = flags[`SLP_FLG_Z];
      2'b01:   sel_flag = flags[`SLP_FLG_C];
      2'b10:   sel_flag = flags[`SLP_FLG_PV];
      default: sel_flag = flags[`SLP_FLG_S];
    endcase
    cond_met = (sel_flag == cond_field[0]);
    byte_out = byte_in & ~(8'h01 << bit_num);
  end

endmodule // slp_exec_unit

// ==== hdl/slp_core.sv ====
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "slp_params.svh"

// Functional notes
// - Push lowers stack pointer two, then stores
// - Low byte first; flags low for pair
// - Push keeps flags; may warn overflow
// - Pair push 11 rr0 101 decoding
// - Index push prefix then 11 100 101
// - Immediate push, low byte then high
// - Direct address push reads memory word
// - Indirect pair three and relative push
// - Bit clear zeroes one bit only
// - Indexed bit clear, displacement before opcode
// - Conditional return pops when condition met
// - Condition tests zero, carry, sign, parity
// - Unconditional return always pops counter
// - Interrupt return pops counter, adds two
// - Interrupt return emits end-of-service cycles
// - Interrupt returns privileged, keep flags
// - Long return pops status, then counter, four
// - Pop low byte first, add two
module slp_core import slp_pkg::*; (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Stack memory byte bus
  output slp_mem_req_t     mem_bus,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  // State
  output logic             core_busy
);

  // Maps a byte register field to its slot and half
  function automatic logic [4:0] reg8_slot(input logic [2:0] r);
    case (r)
      3'h0:    reg8_slot = {`SLP_R_GP1, 1'b1};
      3'h1:    reg8_slot = {`SLP_R_GP1, 1'b0};
      3'h2:    reg8_slot = {`SLP_R_GP2, 1'b1};
      3'h3:    reg8_slot = {`SLP_R_GP2, 1'b0};
      3'h4:    reg8_slot = {`SLP_R_GP3, 1'b1};
      3'h5:    reg8_slot = {`SLP_R_GP3, 1'b0};
      default: reg8_slot = {`SLP_R_ACCF, 1'b1};
    endcase
  endfunction

  slp_aphase_t  aph_q, aph_d;
  logic [31:0]  hrdata_d;

  slp_state_t   st_q, st_d;
  slp_kind_t    kind_q, kind_d;
  slp_mem_req_t mem_q, mem_d;
  logic [15:0]  arch_q [`SLP_ARCH_NUM];
  logic [15:0]  arch_d [`SLP_ARCH_NUM];
  logic [31:0]  instr_q, instr_d;
  logic [31:0]  rbuf_q, rbuf_d;
  logic [15:0]  wword_q, wword_d;
  logic [1:0]   cnt_q, cnt_d;
  logic [1:0]   last_q, last_d;
  logic         sys_q, sys_d;
  logic [`SLP_ST_W-1:0] stat_q, stat_d;

  logic         cond_met;
  logic [7:0]   clr_in;
  logic [7:0]   clr_out;
  logic [2:0]   clr_bit;
  logic [4:0]   clr_slot;

  wire logic [7:0] b0 = instr_q[7:0];
  wire logic [7:0] b1 = instr_q[15:8];
  wire logic [7:0] b2 = instr_q[23:16];
  wire logic [7:0] b3 = instr_q[31:24];

  slp_exec_unit u_exec (
    .flags      (arch_q[`SLP_R_ACCF][7:0]),
    .cond_field (b0[5:3]),
    .cond_met   (cond_met),
    .byte_in    (clr_in),
    .bit_num    (clr_bit),
    .byte_out   (clr_out)
  );

  // Bit clear operand: register, or the byte arriving from memory
  always_comb begin
    clr_slot = reg8_slot(b1[2:0]);
    clr_bit  = (b0 == `SLP_OP_PFX_BIT) ? b1[5:3] : b3[5:3];
    if (b0 == `SLP_OP_PFX_BIT && b1[2:0] != 3'b110) begin
      clr_in = clr_slot[0] ? arch_q[clr_slot[4:1]][15:8] : arch_q[clr_slot[4:1]][7:0];
    end else begin
      clr_in = mem_rdata;
    end
  end

  // AHB address phase; zero wait states so read data is prepared here
  always_comb begin
    aph_d    = '{wr: 1'b0, idx: 6'h00};
    hrdata_d = 32'h0000_0000;
    if (hready && hsel && htrans[1]) begin
      aph_d.wr  = hwrite;
      aph_d.idx = haddr[7:2];
      if (!hwrite) begin
        case (haddr[7:2])
          `SLP_IDX_CTRL:   hrdata_d = {30'h0, sys_q, 1'b0};
          `SLP_IDX_STATUS: hrdata_d = {27'h0, stat_q[`SLP_ST_W-1:1], st_q != SLP_S_IDLE};
          `SLP_IDX_INSTR:  hrdata_d = instr_q;
          default: begin
            if (haddr[7:2] >= `SLP_IDX_ARCH0 &&
                haddr[7:2] < `SLP_IDX_ARCH0 + 6'(`SLP_ARCH_NUM)) begin
              hrdata_d = {16'h0000, arch_q[4'(haddr[7:2] - `SLP_IDX_ARCH0)]};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q     <= '{wr: 1'b0, idx: 6'h00};
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      aph_q     <= aph_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Execution sequencer and architectural state
  always_comb begin
    logic        push_go;
    logic [15:0] push_w;
    logic        rd_go;
    logic [15:0] rd_a;
    logic [1:0]  rd_n;
    logic [15:0] len;
    logic [15:0] sp_new;
    logic        is_x;
    logic [15:0] xy;
    push_go = 1'b0;
    push_w  = 16'h0000;
    rd_go   = 1'b0;
    rd_a    = 16'h0000;
    rd_n    = 2'h0;
    len     = 16'h0001;
    sp_new  = arch_q[`SLP_R_SP] - `SLP_STEP_WORD;
    is_x    = (b0 == `SLP_OP_PFX_X) || (b0 == `SLP_OP_PFX_Y);
    xy      = b0[5] ? arch_q[`SLP_R_IDX2] : arch_q[`SLP_R_IDX1];
    st_d    = st_q;
    kind_d  = kind_q;
    mem_d   = mem_q;
    arch_d  = arch_q;
    instr_d = instr_q;
    rbuf_d  = rbuf_q;
    wword_d = wword_q;
    cnt_d   = cnt_q;
    last_d  = last_q;
    sys_d   = sys_q;
    stat_d  = stat_q;

    // Software access; clears land before hardware sets below
    if (aph_q.wr) begin
      if (aph_q.idx == `SLP_IDX_STATUS) begin
        stat_d = stat_q & ~hwdata[`SLP_ST_W-1:0];
      end else if (st_q == SLP_S_IDLE) begin
        if (aph_q.idx == `SLP_IDX_CTRL) begin
          sys_d = hwdata[`SLP_CTRL_SYS];
          if (hwdata[`SLP_CTRL_START]) begin
            st_d = SLP_S_EXEC;
          end
        end else if (aph_q.idx == `SLP_IDX_INSTR) begin
          instr_d = hwdata;
        end else if (aph_q.idx >= `SLP_IDX_ARCH0 &&
                     aph_q.idx < `SLP_IDX_ARCH0 + 6'(`SLP_ARCH_NUM)) begin
          arch_d[4'(aph_q.idx - `SLP_IDX_ARCH0)] = hwdata[15:0];
        end
      end
    end

    case (st_q)
      SLP_S_IDLE: begin
      end
      SLP_S_EXEC: begin
        st_d   = SLP_S_FIN;
        kind_d = SLP_K_NONE;
        if ((b0 & 8'hCF) == 8'hC5) begin
          push_go = 1'b1;
          push_w  = arch_q[b0[5:4]];
        end else if (is_x && b1 == `SLP_OP_PUSH_X) begin
          push_go = 1'b1;
          push_w  = xy;
          len     = 16'h0002;
        end else if (b0 == `SLP_OP_PFX_Y && b1 == `SLP_OP_PUSH_IM) begin
          push_go = 1'b1;
          push_w  = {b3, b2};
          len     = 16'h0004;
        end else if (b0 == `SLP_OP_PFX_X && b1 == `SLP_OP_PUSH_IR) begin
          rd_go   = 1'b1;
          rd_a    = arch_q[`SLP_R_GP3];
          len     = 16'h0002;
        end else if (b0 == `SLP_OP_PFX_X && b1 == `SLP_OP_PUSH_DA) begin
          rd_go   = 1'b1;
          rd_a    = {b3, b2};
          len     = 16'h0004;
        end else if (b0 == `SLP_OP_PFX_X && b1 == `SLP_OP_PUSH_RA) begin
          rd_go   = 1'b1;
          rd_a    = arch_q[`SLP_R_PC] + 16'h0004 + {b3, b2};
          len     = 16'h0004;
        end else if (is_x && b1 == `SLP_OP_PFX_BIT && b3[7:6] == 2'b10 &&
                     b3[2:0] == 3'b110) begin
          rd_go   = 1'b1;
          rd_a    = xy + {{8{b2[7]}}, b2};
          len     = 16'h0004;
          kind_d  = SLP_K_BCLR_MEM;
        end else if (b0 == `SLP_OP_PFX_BIT && b1[7:6] == 2'b10) begin
          len = 16'h0002;
          if (b1[2:0] == 3'b110) begin
            rd_go  = 1'b1;
            rd_a   = arch_q[`SLP_R_GP3];
            kind_d = SLP_K_BCLR_MEM;
          end else if (clr_slot[0]) begin
            arch_d[clr_slot[4:1]][15:8] = clr_out;
          end else begin
            arch_d[clr_slot[4:1]][7:0] = clr_out;
          end
        end else if (b0 == `SLP_OP_RTN ||
                     (b0[7:6] == 2'b11 && b0[2:0] == 3'b000 && cond_met)) begin
          rd_go  = 1'b1;
          rd_a   = arch_q[`SLP_R_SP];
          rd_n   = 2'h1;
          kind_d = SLP_K_RTN;
        end else if (b0[7:6] == 2'b11 && b0[2:0] == 3'b000) begin
          len = 16'h0001;
        end else if (b0 == `SLP_OP_PFX_ED &&
                     (b1 == `SLP_OP_IRTN || b1 == `SLP_OP_IRTN_LONG)) begin
          if (!sys_q) begin
            stat_d[`SLP_ST_PRIV] = 1'b1;
            len = 16'h0000;
          end else begin
            rd_go  = 1'b1;
            rd_a   = arch_q[`SLP_R_SP];
            rd_n   = (b1 == `SLP_OP_IRTN) ? 2'h1 : 2'h3;
            kind_d = (b1 == `SLP_OP_IRTN) ? SLP_K_IRTN : SLP_K_IRTN_LONG;
          end
        end else begin
          stat_d[`SLP_ST_ILLEGAL] = 1'b1;
          len = 16'h0000;
        end
        // Returns replace the counter later, so advancing it here is harmless
        arch_d[`SLP_R_PC] = arch_q[`SLP_R_PC] + len;
        if (push_go || (rd_go && kind_d == SLP_K_NONE)) begin
          arch_d[`SLP_R_SP] = sp_new;
          if (sp_new < arch_q[`SLP_R_LIMIT]) begin
            stat_d[`SLP_ST_SSOW] = 1'b1;
          end
        end
        if (push_go) begin
          wword_d = push_w;
          mem_d   = '{req: 1'b1, we: 1'b1, eoi: 1'b0, addr: sp_new, wdata: push_w[7:0]};
          cnt_d   = 2'h0;
          last_d  = 2'h1;
          st_d    = SLP_S_WR;
        end else if (rd_go) begin
          if (kind_d == SLP_K_NONE) begin
            kind_d = SLP_K_PUSH_MEM;
            rd_n   = 2'h1;
          end
          mem_d  = '{req: 1'b1, we: 1'b0, eoi: 1'b0, addr: rd_a, wdata: 8'h00};
          cnt_d  = 2'h0;
          last_d = rd_n;
          st_d   = SLP_S_RD;
        end
      end
      SLP_S_RD: begin
        if (mem_ack) begin
          rbuf_d[{cnt_q, 3'b000} +: 8] = mem_rdata;
          if (cnt_q != last_q) begin
            cnt_d      = cnt_q + 2'h1;
            mem_d.addr = mem_q.addr + 16'h0001;
          end else begin
            mem_d.req = 1'b0;
            cnt_d     = 2'h0;
            st_d      = SLP_S_FIN;
            case (kind_q)
              SLP_K_PUSH_MEM: begin
                wword_d = {mem_rdata, rbuf_q[7:0]};
                mem_d   = '{req: 1'b1, we: 1'b1, eoi: 1'b0,
                            addr: arch_q[`SLP_R_SP], wdata: rbuf_q[7:0]};
                last_d  = 2'h1;
                st_d    = SLP_S_WR;
              end
              SLP_K_BCLR_MEM: begin
                mem_d   = '{req: 1'b1, we: 1'b1, eoi: 1'b0,
                            addr: mem_q.addr, wdata: clr_out};
                last_d  = 2'h0;
                st_d    = SLP_S_WR;
              end
              SLP_K_RTN, SLP_K_IRTN: begin
                arch_d[`SLP_R_PC] = {mem_rdata, rbuf_q[7:0]};
                arch_d[`SLP_R_SP] = arch_q[`SLP_R_SP] + `SLP_STEP_WORD;
                if (kind_q == SLP_K_IRTN) begin
                  // Echo both opcode bytes as marked writes at the old counter
                  mem_d  = '{req: 1'b1, we: 1'b1, eoi: 1'b1,
                             addr: arch_q[`SLP_R_PC] - 16'h0001,
                             wdata: `SLP_OP_PFX_ED};
                  last_d = 2'h1;
                  st_d   = SLP_S_SEQ;
                end
              end
              SLP_K_IRTN_LONG: begin
                arch_d[`SLP_R_MSW] = rbuf_q[15:0];
                arch_d[`SLP_R_PC]  = {mem_rdata, rbuf_q[23:16]};
                arch_d[`SLP_R_SP]  = arch_q[`SLP_R_SP] + `SLP_STEP_LONG;
              end
              default: begin
              end
            endcase
          end
        end
      end
      SLP_S_WR, SLP_S_SEQ: begin
        if (mem_ack) begin
          if (cnt_q != last_q) begin
            cnt_d       = cnt_q + 2'h1;
            mem_d.addr  = mem_q.addr + 16'h0001;
            mem_d.wdata = (st_q == SLP_S_SEQ) ? `SLP_OP_IRTN : wword_q[15:8];
          end else begin
            mem_d = '{req: 1'b0, we: 1'b0, eoi: 1'b0, addr: 16'h0000, wdata: 8'h00};
            st_d  = SLP_S_FIN;
          end
        end
      end
      SLP_S_FIN: begin
        stat_d[`SLP_ST_DONE] = 1'b1;
        st_d = SLP_S_IDLE;
      end
      default: begin
        st_d = SLP_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= SLP_S_IDLE;
      kind_q    <= SLP_K_NONE;
      mem_q     <= '{req: 1'b0, we: 1'b0, eoi: 1'b0, addr: 16'h0000, wdata: 8'h00};
      for (int i = 0; i < `SLP_ARCH_NUM; i++) begin
        arch_q[i] <= `SLP_RST_REG;
      end
      instr_q   <= 32'h0000_0000;
      rbuf_q    <= 32'h0000_0000;
      wword_q   <= 16'h0000;
      cnt_q     <= 2'h0;
      last_q    <= 2'h0;
      sys_q     <= 1'b0;
      stat_q    <= `SLP_RST_STATUS;
      core_busy <= 1'b0;
    end else begin
      st_q      <= st_d;
      kind_q    <= kind_d;
      mem_q     <= mem_d;
      arch_q    <= arch_d;
      instr_q   <= instr_d;
      rbuf_q    <= rbuf_d;
      wword_q   <= wword_d;
      cnt_q     <= cnt_d;
      last_q    <= last_d;
      sys_q     <= sys_d;
      stat_q    <= stat_d;
      core_busy <= (st_d != SLP_S_IDLE);
    end
  end

  assign mem_bus = mem_q;

endmodule // slp_core

// ==== tb/slp_mem_model.sv ====
`timescale 1ns/100ps
module slp_mem_model import slp_pkg::*; (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Byte bus from the core
  input  wire slp_mem_req_t mem_bus,
  input  wire logic         slow,
  output logic              mem_ack,
  output logic [7:0]        mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_q;

  // Slow mode answers after three idle cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= 8'h5A;
    end else if (mem_bus.req && !mem_ack && (wait_q == 2'h3 || !slow)) begin
      mem_ack   <= 1'b1;
      wait_q    <= 2'h0;
      mem_rdata <= mem[mem_bus.addr];
    end else begin
      mem_ack   <= 1'b0;
      wait_q    <= (mem_bus.req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      // Byte is gone after its ack cycle, so never leave it standing
      mem_rdata <= ~mem_rdata;
    end
  end

  always @(posedge hclk) begin
    if (mem_bus.req && mem_bus.we && mem_ack)
      mem[mem_bus.addr] <= mem_bus.wdata;
  end
endmodule // slp_mem_model

// ==== tb/slp_core_monitor.sv ====
`timescale 1ns/100ps
module slp_core_monitor import slp_pkg::*; (
  // Clock and reset
  input wire logic         hclk,
  input wire logic         hresetn,
  // AHB side
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [31:0]  hwdata,
  input wire logic         hready,
  // Stack memory side
  input wire slp_mem_req_t mem_bus,
  input wire logic         mem_ack,
  input wire logic         core_busy
);
  default clocking mon_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_idle_no_mem: assert property (!core_busy |-> !mem_bus.req)
    else $error("memory request outside an instruction");
  a_req_holds: assert property (mem_bus.req && !mem_ack |=> mem_bus.req &&
    $stable(mem_bus.addr) && $stable(mem_bus.we) && $stable(mem_bus.wdata))
    else $error("byte request changed before ack");
  a_byte_ascend: assert property ((mem_bus.req && mem_ack) ##1
    (mem_bus.req && mem_bus.we == $past(mem_bus.we))
    |-> mem_bus.addr == $past(mem_bus.addr) + 16'h0001)
    else $error("next byte not at address plus one");
  a_eoi_write: assert property (mem_bus.req && mem_bus.eoi |-> mem_bus.we)
    else $error("end of service cycle is not a write");
  a_eoi_first: assert property ($rose(mem_bus.eoi) |-> mem_bus.wdata == 8'hED)
    else $error("end of service sequence does not open with ED");
  a_eoi_second: assert property (mem_bus.eoi && mem_bus.req && mem_ack &&
    mem_bus.wdata == 8'hED |=> mem_bus.eoi && mem_bus.wdata == 8'h4D)
    else $error("end of service second byte wrong");
  a_busy_bounded: assert property ($rose(core_busy) |-> ##[1:400] !core_busy)
    else $error("instruction did not finish");
  a_start_runs: assert property ((hsel && htrans[1] && hready && hwrite &&
    haddr[7:2] == 6'h00 && !core_busy) ##1 hwdata[0] |-> ##[1:2] core_busy)
    else $error("start did not launch execution");
endmodule // slp_core_monitor

bind slp_core slp_core_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .mem_bus(mem_bus),
  .mem_ack(mem_ack), .core_busy(core_busy)
);

// ==== tb/stack_push_return_bitclear_bench.sv ====
`timescale 1ns/100ps
`include "slp_params.svh"
module stack_push_return_bitclear_bench import slp_pkg::*; ;
  logic         hclk, hresetn, hsel, hwrite, mem_ack, slow, core_busy, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [7:0]   mem_rdata;
  logic [15:0]  sp;
  wire logic    hready;
  slp_mem_req_t mem_bus;
  int           errors, cmp_count;

  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  slp_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_bus(mem_bus),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .core_busy(core_busy));
  slp_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem_bus(mem_bus), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) begin
      errors++;
      summarize();
    end
  endtask
  task automatic ahb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, idx, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    ahb(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask
  function automatic logic [5:0] ax(input logic [3:0] s);
    return 6'(`SLP_IDX_ARCH0 + s);
  endfunction
  task automatic run(input logic [31:0] ins, input logic sys);
    int n;
    wr(`SLP_IDX_INSTR, ins);
    wr(`SLP_IDX_CTRL, {30'h0, sys, 1'b1});
    n = 0;
    repeat (3) @(posedge hclk);
    while (core_busy !== 1'b0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 500) begin
      errors++;
      summarize();
    end
  endtask
  task automatic push(input logic [31:0] ins, input logic [15:0] w);
    run(ins, 1'b1);
    check({16'h0, u_mem.mem[sp - 16'h1], u_mem.mem[sp - 16'h2]}, {16'h0, w});
    rdc(ax(`SLP_R_SP), {16'h0, sp - 16'h2});
    sp = sp - 16'h2;
  endtask
  task automatic stat(input logic [31:0] exp);
    ahb(1'b0, `SLP_IDX_STATUS, 32'h0);
    check(rd & 32'h1C, exp);
    wr(`SLP_IDX_STATUS, 32'h1E);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    slow = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(6'h3F, 32'h0);
    sp = 16'hFE34;
    wr(ax(`SLP_R_SP), {16'h0, sp});
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      wr(ax(4'(i)), 32'h0923 + i * 32'h1111);
      push(32'hC5 | (i << 4), 16'h0923 + 16'(i) * 16'h1111);
      rdc(ax(4'(i)), 32'h0923 + i * 32'h1111);
    end
    wr(ax(`SLP_R_IDX1), 32'hA1B2);
    wr(ax(`SLP_R_IDX2), 32'hC3D4);
    push(32'h0000E5DD, 16'hA1B2);
    push(32'h0000E5FD, 16'hC3D4);
    push(32'h1234F5FD, 16'h1234);
    u_mem.mem[16'h2000] = 8'hCD;
    u_mem.mem[16'h2001] = 8'hAB;
    push(32'h2000D5DD, 16'hABCD);
    wr(ax(`SLP_R_GP3), 32'h2000);
    push(32'h0000C5DD, 16'hABCD);
    wr(ax(`SLP_R_PC), 32'h1FF0);
    push(32'h000CF5DD, 16'hABCD);
    wr(ax(`SLP_R_LIMIT), 32'hFFFF);
    push(32'h000000C5, 16'h0923);
    stat(32'h08);
    wr(ax(`SLP_R_LIMIT), 32'h0);
    $display("test push done");
    for (int b = 0; b < 8; b++) begin
      wr(ax(`SLP_R_ACCF), 32'hFFC5);
      run({16'h0, 2'h2, 3'(b), 3'h7, 8'hCB}, 1'b1);
      rdc(ax(`SLP_R_ACCF), {16'h0, 8'hFF & ~(8'h1 << b), 8'hC5});
    end
    wr(ax(`SLP_R_IDX1), 32'h3000);
    u_mem.mem[16'h3005] = 8'hFF;
    run(32'hBE05CBDD, 1'b1);
    check({24'h0, u_mem.mem[16'h3005]}, 32'h7F);
    run(32'h000086CB, 1'b1);
    check({24'h0, u_mem.mem[16'h2000]}, 32'hCC);
    $display("test bit clear done");
    u_mem.mem[16'hFF00] = 8'h72;
    u_mem.mem[16'hFF01] = 8'h19;
    for (int k = 0; k < 17; k++) begin
      slow <= k[0];
      wr(ax(`SLP_R_ACCF), k[3] ? 32'hC5 : 32'h0);
      wr(ax(`SLP_R_SP), 32'hFF00);
      wr(ax(`SLP_R_PC), 32'h0100);
      run(k == 16 ? 32'hC9 : {24'h0, 2'h3, 3'(k), 3'h0}, 1'b1);
      rdc(ax(`SLP_R_PC), (k[0] == k[3] || k == 16) ? 32'h1972 : 32'h0101);
      rdc(ax(`SLP_R_SP), (k[0] == k[3] || k == 16) ? 32'hFF02 : 32'hFF00);
    end
    $display("test return done");
    u_mem.mem[16'hFFC6] = 8'h72;
    u_mem.mem[16'hFFC7] = 8'h19;
    wr(ax(`SLP_R_SP), 32'hFFC6);
    wr(ax(`SLP_R_PC), 32'h8410);
    run(32'h4DED, 1'b0);
    stat(32'h04);
    rdc(ax(`SLP_R_PC), 32'h8410);
    run(32'h4DED, 1'b1);
    rdc(ax(`SLP_R_PC), 32'h1972);
    rdc(ax(`SLP_R_SP), 32'hFFC8);
    check({16'h0, u_mem.mem[16'h8411], u_mem.mem[16'h8410]}, 32'h4DED);
    u_mem.mem[16'hFFC6] = 8'h7F;
    u_mem.mem[16'hFFC7] = 8'h40;
    u_mem.mem[16'hFFC8] = 8'h72;
    u_mem.mem[16'hFFC9] = 8'h19;
    wr(ax(`SLP_R_SP), 32'hFFC6);
    run(32'h55ED, 1'b1);
    rdc(ax(`SLP_R_MSW), 32'h407F);
    rdc(ax(`SLP_R_PC), 32'h1972);
    rdc(ax(`SLP_R_SP), 32'hFFCA);
    run(32'h55ED, 1'b0);
    stat(32'h04);
    run(32'h0000_0000, 1'b1);
    stat(32'h10);
    rdc(ax(`SLP_R_PC), 32'h1972);
    $display("test interrupt return done");
    summarize();
  end
endmodule // stack_push_return_bitclear_bench
